// ==== pkg/phy_cfg_pkg.sv ====
// constants shared by the configuration register bank and its indicator selector
package phy_cfg_pkg;

  // ==========================================================
  // register indices and bus addresses (byte address is four times the index)
  localparam logic [15:0] dsp_config_six_idx        = 16'h0450;
  localparam logic [15:0] general_config_idx        = 16'h0456;
  localparam logic [15:0] led_source_config_idx     = 16'h0460;
  localparam logic [15:0] pin_impedance_control_idx = 16'h0461;
  localparam logic [15:0] indicator_status_idx      = 16'h0470;
  localparam int          addr_w                    = 16;

  // ==========================================================
  // reset values
  localparam logic [15:0] dsp_config_six_rst        = 16'h0141;
  localparam logic [15:0] general_config_rst        = 16'h0008;
  localparam logic [15:0] led_source_config_rst     = 16'h0551;
  localparam logic [15:0] pin_impedance_control_rst = 16'h0410;
  localparam logic [15:0] led_cfg_write_mask        = 16'h0fff;

  // ==========================================================
  // field positions
  localparam int eq_cal_bypass_bit = 13;
  localparam int min_ipg_bit       = 3;
  localparam int first_src_lsb     = 8;
  localparam int third_src_lsb     = 4;
  localparam int term_code_lsb     = 1;
  localparam int code_w            = 4;

  // ==========================================================
  // indicator source codes
  localparam logic [3:0] src_link_ok      = 4'h0;
  localparam logic [3:0] src_activity     = 4'h1;
  localparam logic [3:0] src_tx_activity  = 4'h2;
  localparam logic [3:0] src_rx_activity  = 4'h3;
  localparam logic [3:0] src_collision    = 4'h4;
  localparam logic [3:0] src_speed_100    = 4'h5;
  localparam logic [3:0] src_speed_10     = 4'h6;
  localparam logic [3:0] src_full_duplex  = 4'h7;
  localparam logic [3:0] src_link_blink   = 4'h8;
  localparam logic [3:0] src_stretch      = 4'h9;
  localparam logic [3:0] src_link_100_fd  = 4'ha;
  localparam logic [3:0] src_lpi          = 4'hb;
  localparam logic [3:0] src_mac_error    = 4'hc;
  localparam logic [3:0] src_link_lost    = 4'hd;
  localparam logic [3:0] src_prbs_error   = 4'he;

  // ==========================================================
  // timing
  localparam int clk_period_ns  = 50;
  localparam int ipg_min_ns     = 120;
  localparam int ipg_normal_ns  = 200;
  localparam int ipg_min_cyc    = (ipg_min_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int ipg_normal_cyc = (ipg_normal_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int ipg_cnt_w      = 4;
  localparam int blink_ms       = 50;
  localparam int blink_cyc      = blink_ms * 1000000 / clk_period_ns;
  localparam int stretch_ticks  = 2;

  // ==========================================================
  // bus encodings
  localparam logic [1:0] htrans_nonseq = 2'b10;
  localparam logic [2:0] hsize_word    = 3'b010;

endpackage

// ==== design/indicator_source_mux.sv ====
// selects one indicator level from the fifteen documented sources
`timescale 1ns/1ps
`default_nettype none

module indicator_source_mux
(
  input  wire logic [3:0] code_i,
  input  wire logic       link_up_i,
  input  wire logic       rx_act_i,
  input  wire logic       tx_act_i,
  input  wire logic       collision_i,
  input  wire logic       speed_100_i,
  input  wire logic       full_duplex_i,
  input  wire logic       blink_phase_i,
  input  wire logic       stretch_i,
  input  wire logic       lpi_i,
  input  wire logic       mac_error_i,
  input  wire logic       link_lost_i,
  input  wire logic       prbs_latch_i,
  output logic            level_o
);
  import phy_cfg_pkg::*;

  // ==========================================================
  // source decode; reserved code gives a dark indicator
  always_comb
  begin
    level_o = 1'b0;
    case (code_i)
      src_link_ok:     level_o = link_up_i;
      src_activity:    level_o = rx_act_i | tx_act_i;
      src_tx_activity: level_o = tx_act_i;
      src_rx_activity: level_o = rx_act_i;
      src_collision:   level_o = collision_i;
      src_speed_100:   level_o = link_up_i & speed_100_i;
      src_speed_10:    level_o = link_up_i & ~speed_100_i;
      src_full_duplex: level_o = full_duplex_i;
      // blink only dims the light while traffic is seen
      src_link_blink:  level_o = link_up_i & ~((rx_act_i | tx_act_i) & blink_phase_i);
      src_stretch:     level_o = stretch_i;
      src_link_100_fd: level_o = link_up_i & speed_100_i & full_duplex_i;
      src_lpi:         level_o = lpi_i;
      src_mac_error:   level_o = mac_error_i;
      src_link_lost:   level_o = link_lost_i;
      src_prbs_error:  level_o = prbs_latch_i;
      default:         level_o = 1'b0;
    endcase
  end

endmodule

`default_nettype wire

// ==== design/phy_led_ipg_config_regs.sv ====
// configuration register bank: eq bypass, gap, indicator sources, termination
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module phy_led_ipg_config_regs
#(
  parameter int blink_cycles = phy_cfg_pkg::blink_cyc
)
(
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  // ahb-lite slave
  input  wire logic                          hsel_i,
  input  wire logic [phy_cfg_pkg::addr_w-1:0] haddr_i,
  input  wire logic [1:0]                    htrans_i,
  input  wire logic                          hwrite_i,
  input  wire logic [2:0]                    hsize_i,
  input  wire logic [31:0]                   hwdata_i,
  input  wire logic                          hready_i,
  output logic      [31:0]                   hrdata_o,
  output logic                               hreadyout_o,
  output logic                               hresp_o,
  // phy status inputs
  input  wire logic                          link_up_i,
  input  wire logic                          rx_act_i,
  input  wire logic                          tx_act_i,
  input  wire logic                          collision_i,
  input  wire logic                          speed_100_i,
  input  wire logic                          full_duplex_i,
  input  wire logic                          lpi_i,
  input  wire logic                          mac_error_i,
  input  wire logic                          prbs_error_i,
  input  wire logic                          basic_status_read_i,
  input  wire logic                          selftest_clear_i,
  input  wire logic                          frame_end_i,
  input  wire logic                          cal_request_i,
  // controls and indicators
  output logic                               first_indicator_pin_o,
  output logic                               third_indicator_function_o,
  output logic                               eq_cal_bypass_o,
  output logic                               eq_cal_start_o,
  output logic                               gap_open_o,
  output logic      [3:0]                    mac_term_code_o
);
  import phy_cfg_pkg::*;

  // ==========================================================
  // declarations
  logic [15:0]       dsp_config_six;
  logic [15:0]       general_config;
  logic [15:0]       led_source_config;
  logic [15:0]       pin_impedance_control;
  logic              wr_pending;
  logic [addr_w-1:0] wr_addr;
  logic              addr_phase;
  logic [15:0]       next_rdata;
  logic              link_prev;
  logic              link_lost;
  logic              prbs_latch;
  logic [31:0]       blink_cnt;
  logic              blink_tick;
  logic              blink_phase;
  logic [1:0]        stretch_cnt;
  logic              stretch;
  logic [ipg_cnt_w-1:0] gap_cnt;
  logic              first_level;
  logic              third_level;
  logic [15:0]       indicator_status;

  // ==========================================================
  // bus address phase: only whole-word nonseq transfers are acted on
  assign addr_phase = hsel_i & hready_i & (htrans_i == htrans_nonseq) & (hsize_i == hsize_word);

  // response is always okay with no wait state
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
    else
    begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  // remember a write address until its data phase
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wr_pending <= 1'b0;
      wr_addr    <= '0;
    end
    else if (hready_i)
    begin
      wr_pending <= addr_phase & hwrite_i;
      wr_addr    <= haddr_i;
    end
  end

  // ==========================================================
  // read mux; unmapped addresses return zero
  always_comb
  begin
    next_rdata = 16'h0000;
    if (haddr_i == {dsp_config_six_idx[addr_w-3:0], 2'b00})
      next_rdata = dsp_config_six;
    else if (haddr_i == {general_config_idx[addr_w-3:0], 2'b00})
      next_rdata = general_config;
    else if (haddr_i == {led_source_config_idx[addr_w-3:0], 2'b00})
      next_rdata = led_source_config;
    else if (haddr_i == {pin_impedance_control_idx[addr_w-3:0], 2'b00})
      next_rdata = pin_impedance_control;
    else if (haddr_i == {indicator_status_idx[addr_w-3:0], 2'b00})
      next_rdata = indicator_status;
  end

  // read data is captured at the address phase so it stands in the data phase
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      hrdata_o <= 32'h0000_0000;
    else if (addr_phase & ~hwrite_i)
      hrdata_o <= {16'h0000, next_rdata};
  end

  // ==========================================================
  // register writes, in the data phase; reserved bits keep what was written, except the led source top nibble
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dsp_config_six        <= dsp_config_six_rst;
      general_config        <= general_config_rst;
      led_source_config     <= led_source_config_rst;
      pin_impedance_control <= pin_impedance_control_rst;
    end
    else if (wr_pending)
    begin
      if (wr_addr == {dsp_config_six_idx[addr_w-3:0], 2'b00})
        dsp_config_six <= hwdata_i[15:0];
      else if (wr_addr == {general_config_idx[addr_w-3:0], 2'b00})
        general_config <= hwdata_i[15:0];
      else if (wr_addr == {led_source_config_idx[addr_w-3:0], 2'b00})
        // top nibble is read-only zero
        led_source_config <= hwdata_i[15:0] & led_cfg_write_mask;
      else if (wr_addr == {pin_impedance_control_idx[addr_w-3:0], 2'b00})
        pin_impedance_control <= hwdata_i[15:0];
    end
  end

  // ==========================================================
  // link-drop latch; a new drop in the clearing cycle wins
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      link_prev <= 1'b0;
      link_lost <= 1'b0;
    end
    else
    begin
      link_prev <= link_up_i;
      if (link_prev & ~link_up_i)
        link_lost <= 1'b1;
      else if (basic_status_read_i)
        link_lost <= 1'b0;
    end
  end

  // single prbs error latch, cleared by the selftest status clear
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      prbs_latch <= 1'b0;
    else if (prbs_error_i)
      prbs_latch <= 1'b1;
    else if (selftest_clear_i)
      prbs_latch <= 1'b0;
  end

  // ==========================================================
  // blink divider: one-cycle tick every blink period
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      blink_cnt  <= 32'h0000_0000;
      blink_tick <= 1'b0;
    end
    else if (blink_cnt >= 32'(blink_cycles - 1))
    begin
      blink_cnt  <= 32'h0000_0000;
      blink_tick <= 1'b1;
    end
    else
    begin
      blink_cnt  <= blink_cnt + 32'h0000_0001;
      blink_tick <= 1'b0;
    end
  end

  // blink phase toggles once per tick
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      blink_phase <= 1'b0;
    else if (blink_tick)
      blink_phase <= ~blink_phase;
  end

  // stretched activity holds for one to two blink periods so short bursts stay visible
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stretch_cnt <= 2'b00;
      stretch     <= 1'b0;
    end
    else if (rx_act_i | tx_act_i)
    begin
      stretch_cnt <= 2'(stretch_ticks);
      stretch     <= 1'b1;
    end
    else if (blink_tick && stretch_cnt != 2'b00)
    begin
      stretch_cnt <= stretch_cnt - 2'b01;
      stretch     <= (stretch_cnt != 2'b01);
    end
  end

  // ==========================================================
  // the two indicator selectors share every source
  indicator_source_mux first_mux
  (
    .code_i        (led_source_config[first_src_lsb +: code_w]),
    .link_up_i     (link_up_i),
    .rx_act_i      (rx_act_i),
    .tx_act_i      (tx_act_i),
    .collision_i   (collision_i),
    .speed_100_i   (speed_100_i),
    .full_duplex_i (full_duplex_i),
    .blink_phase_i (blink_phase),
    .stretch_i     (stretch),
    .lpi_i         (lpi_i),
    .mac_error_i   (mac_error_i),
    .link_lost_i   (link_lost),
    .prbs_latch_i  (prbs_latch),
    .level_o       (first_level)
  );

  indicator_source_mux third_mux
  (
    .code_i        (led_source_config[third_src_lsb +: code_w]),
    .link_up_i     (link_up_i),
    .rx_act_i      (rx_act_i),
    .tx_act_i      (tx_act_i),
    .collision_i   (collision_i),
    .speed_100_i   (speed_100_i),
    .full_duplex_i (full_duplex_i),
    .blink_phase_i (blink_phase),
    .stretch_i     (stretch),
    .lpi_i         (lpi_i),
    .mac_error_i   (mac_error_i),
    .link_lost_i   (link_lost),
    .prbs_latch_i  (prbs_latch),
    .level_o       (third_level)
  );

  // indicator pins are registered, one cycle behind their source
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      first_indicator_pin_o      <= 1'b0;
      third_indicator_function_o <= 1'b0;
    end
    else
    begin
      first_indicator_pin_o      <= first_level;
      third_indicator_function_o <= third_level;
    end
  end

  // ==========================================================
  // inter-packet gap: gap_open_o drops after a frame end for the selected count
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      gap_cnt    <= '0;
      gap_open_o <= 1'b1;
    end
    else if (frame_end_i)
    begin
      if (general_config[min_ipg_bit])
        gap_cnt <= ipg_cnt_w'(ipg_min_cyc - 1);
      else
        gap_cnt <= ipg_cnt_w'(ipg_normal_cyc - 1);
      gap_open_o <= 1'b0;
    end
    else if (gap_cnt != '0)
    begin
      gap_cnt    <= gap_cnt - 1'b1;
      gap_open_o <= 1'b0;
    end
    else
      gap_open_o <= 1'b1;
  end

  // ==========================================================
  // calibration request passes only when bypass is clear
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      eq_cal_bypass_o <= 1'b0;
      eq_cal_start_o  <= 1'b0;
    end
    else
    begin
      eq_cal_bypass_o <= dsp_config_six[eq_cal_bypass_bit];
      eq_cal_start_o  <= cal_request_i & ~dsp_config_six[eq_cal_bypass_bit];
    end
  end

  // termination code drives the pad strength selection
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      mac_term_code_o <= pin_impedance_control_rst[term_code_lsb +: code_w];
    else
      mac_term_code_o <= pin_impedance_control[term_code_lsb +: code_w];
  end

  // ==========================================================
  // status word seen by software
  assign indicator_status = {10'h000, gap_open_o, prbs_latch, link_lost, stretch,
                             third_indicator_function_o, first_indicator_pin_o};

endmodule

`default_nettype wire

// ==== verification/phy_led_ipg_config_regs_chk.sv ====
// port-level assertion checker for the configuration register bank
`timescale 1ns/1ps
`default_nettype none

module phy_led_ipg_config_regs_chk
#(
  parameter int blink_cycles = phy_cfg_pkg::blink_cyc
)
(
  input wire logic        clk_i,
  input wire logic        nrst_i,
  input wire logic        hsel_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o,
  input wire logic        cal_request_i,
  input wire logic        frame_end_i,
  input wire logic        eq_cal_bypass_o,
  input wire logic        eq_cal_start_o,
  input wire logic        gap_open_o,
  input wire logic [3:0]  mac_term_code_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // ==========================================================
  // helper: a write address phase taken by the slave
  logic wr_taken;
  assign wr_taken = hsel_i && hwrite_i && (htrans_i == 2'b10) && hready_i;

  // ==========================================================
  // properties
  property p_ready_high;
    hreadyout_o;
  endproperty
  property p_resp_okay;
    !hresp_o;
  endproperty
  property p_rdata_upper_zero;
    hrdata_o[31:16] == 16'h0000;
  endproperty
  // control mirrors only move three edges after a write address phase
  property p_term_moves_on_write;
    !$stable(mac_term_code_o) |-> $past(wr_taken, 3);
  endproperty
  property p_bypass_moves_on_write;
    !$stable(eq_cal_bypass_o) |-> $past(wr_taken, 3);
  endproperty
  property p_cal_start_gated;
    $past(nrst_i) |-> (eq_cal_start_o == ($past(cal_request_i) && !eq_cal_bypass_o));
  endproperty
  property p_gap_closes;
    frame_end_i |=> !gap_open_o;
  endproperty
  // a gap stays closed for three or four cycles, never fewer or more
  property p_gap_length;
    $fell(gap_open_o) |-> !gap_open_o [*3] ##[1:2] gap_open_o;
  endproperty

  a_ready_high: assert property (p_ready_high)
    else $error("hreadyout low");
  a_resp_okay: assert property (p_resp_okay)
    else $error("hresp not okay");
  a_rdata_upper_zero: assert property (p_rdata_upper_zero)
    else $error("read data upper half not zero");
  a_term_moves_on_write: assert property (p_term_moves_on_write)
    else $error("termination code changed without a write");
  a_bypass_moves_on_write: assert property (p_bypass_moves_on_write)
    else $error("calibration bypass changed without a write");
  a_cal_start_gated: assert property (p_cal_start_gated)
    else $error("calibration start does not follow request and bypass");
  a_gap_closes: assert property (p_gap_closes)
    else $error("gap not closed after frame end");
  a_gap_length: assert property (p_gap_length)
    else $error("gap length wrong");

  c_frame_end: cover property (frame_end_i ##1 !gap_open_o);
  c_term_change: cover property (!$stable(mac_term_code_o));
  c_cal_start: cover property (eq_cal_start_o);
endmodule

bind phy_led_ipg_config_regs phy_led_ipg_config_regs_chk #(.blink_cycles(blink_cycles)) u_chk (
  .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .cal_request_i(cal_request_i), .frame_end_i(frame_end_i), .eq_cal_bypass_o(eq_cal_bypass_o),
  .eq_cal_start_o(eq_cal_start_o), .gap_open_o(gap_open_o), .mac_term_code_o(mac_term_code_o));

`default_nettype wire

// ==== verification/phy_led_ipg_config_regs_bench.sv ====
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none

module phy_led_ipg_config_regs_bench;
  import phy_cfg_pkg::*;

  typedef struct packed {logic [3:0] code; logic [7:0] st; logic exp;} row_type;

  logic        clk_i, nrst_i, hsel_i, hwrite_i, hreadyout_o, hresp_o, calr;
  logic [15:0] haddr_i;
  logic [1:0]  htrans_i;
  logic [2:0]  hsize_i;
  logic [31:0] hwdata_i, hrdata_o;
  logic [7:0]  st;
  logic [3:0]  pv;
  logic [3:0]  mac_term_code_o;
  logic        first_o, third_o, bypass_o, cal_start_o, gap_open_o;
  logic [15:0] q;
  int          n_fail, n_compared, n;
  // status vector: link rx tx col s100 fd lpi macerr
  row_type     rows [20] = '{
    '{4'h0, 8'h80, 1'b1}, '{4'h0, 8'h00, 1'b0}, '{4'h1, 8'h40, 1'b1}, '{4'h1, 8'h00, 1'b0},
    '{4'h2, 8'h20, 1'b1}, '{4'h2, 8'h40, 1'b0}, '{4'h3, 8'h40, 1'b1}, '{4'h3, 8'h20, 1'b0},
    '{4'h4, 8'h10, 1'b1}, '{4'h5, 8'h88, 1'b1}, '{4'h5, 8'h80, 1'b0}, '{4'h6, 8'h80, 1'b1},
    '{4'h7, 8'h84, 1'b1}, '{4'ha, 8'h8c, 1'b1}, '{4'ha, 8'h88, 1'b0}, '{4'hb, 8'h02, 1'b1},
    '{4'hc, 8'h01, 1'b1}, '{4'hf, 8'hff, 1'b0}, '{4'h8, 8'h80, 1'b1}, '{4'h9, 8'h40, 1'b1}};

  // short blink count keeps blinking codes inside a short run
  phy_led_ipg_config_regs #(.blink_cycles(8)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .link_up_i(st[7]), .rx_act_i(st[6]), .tx_act_i(st[5]), .collision_i(st[4]),
    .speed_100_i(st[3]), .full_duplex_i(st[2]), .lpi_i(st[1]), .mac_error_i(st[0]),
    .prbs_error_i(pv[0]), .basic_status_read_i(pv[1]), .selftest_clear_i(pv[2]),
    .frame_end_i(pv[3]), .cal_request_i(calr), .first_indicator_pin_o(first_o),
    .third_indicator_function_o(third_o), .eq_cal_bypass_o(bypass_o),
    .eq_cal_start_o(cal_start_o), .gap_open_o(gap_open_o), .mac_term_code_o(mac_term_code_o));

  // ==========================================================
  // clock and shared tasks
  always #25 clk_i = ~clk_i;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // one single word transfer; only the watchdog bounds the wait loops
  task xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    hsel_i <= 1'b1;
    haddr_i <= a;
    htrans_i <= 2'b10;
    hwrite_i <= w;
    hsize_i <= 3'b010;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'b00;
    hwdata_i <= {16'h0000, d};
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    q = hrdata_o[15:0];
  endtask

  task pulse(input int i);
    @(posedge clk_i);
    pv[i] <= 1'b1;
    @(posedge clk_i);
    pv[i] <= 1'b0;
  endtask

  // outputs are looked at on the falling edge, away from their update
  task settle(input int k);
    repeat (k) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task drive_st(input logic [7:0] v);
    @(posedge clk_i);
    st <= v;
  endtask

  task give_verdict;
    $display("comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (6000) @(posedge clk_i);
    n_fail++;
    give_verdict();
  end

  // ==========================================================
  // main sequence
  initial
  begin
    clk_i = 0; nrst_i = 0; hsel_i = 0; haddr_i = 0; htrans_i = 0; hwrite_i = 0;
    hsize_i = 0; hwdata_i = 0; st = 0; pv = 0; calr = 0; n_fail = 0; n_compared = 0;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'b1;
    settle(1);
    chk(mac_term_code_o, 4'h8);
    chk(bypass_o, 1'b0);
    xfer(0, 16'h1140, 0); chk(q, 16'h0141);
    xfer(0, 16'h1158, 0); chk(q, 16'h0008);
    xfer(0, 16'h1180, 0); chk(q, 16'h0551);
    xfer(0, 16'h1184, 0); chk(q, 16'h0410);
    // every static source code on both indicator outputs
    foreach (rows[i])
    begin
      xfer(1, 16'h1180, {4'h0, rows[i].code, rows[i].code, 4'h1});
      drive_st(rows[i].st);
      settle(4);
      chk(first_o, rows[i].exp);
      chk(third_o, rows[i].exp);
    end
    // upper nibble is read-only, unmapped place reads zero
    xfer(1, 16'h1180, 16'hffff); xfer(0, 16'h1180, 0); chk(q, 16'h0fff);
    xfer(1, 16'h1200, 16'hbeef); xfer(0, 16'h1200, 0); chk(q, 16'h0000);
    // blinking on activity is dark for one whole blink period in every two
    xfer(1, 16'h1180, 16'h0881);
    drive_st(8'hc0);
    settle(2);
    n = 0;
    repeat (16)
    begin
      @(negedge clk_i);
      if (first_o === 1'b1)
        n++;
    end
    chk(n, 8);
    // link lost latches until the basic register is read
    xfer(1, 16'h1180, 16'h0dd1);
    drive_st(8'h80);
    pulse(1);
    settle(3); chk(first_o, 1'b0);
    drive_st(8'h00);
    settle(4); chk(first_o, 1'b1);
    drive_st(8'h80);
    settle(4); chk(third_o, 1'b1);
    pulse(1);
    settle(3); chk(first_o, 1'b0);
    // one prbs error latches until the selftest status is cleared
    xfer(1, 16'h1180, 16'h0ee1);
    pulse(2);
    settle(3); chk(first_o, 1'b0);
    pulse(0);
    settle(6); chk(first_o, 1'b1);
    pulse(2);
    settle(3); chk(first_o, 1'b0);
    @(posedge clk_i);
    pv <= 4'b0101;
    @(posedge clk_i);
    pv <= 4'b0000;
    settle(3); chk(third_o, 1'b1);
    // status word: both indicators and prbs latch lit, gap open, nothing else
    xfer(0, 16'h11c0, 0);
    chk(q, 16'h0033);
    // all sixteen termination codes
    for (int i = 0; i < 16; i++)
    begin
      xfer(1, 16'h1184, {11'h020, i[3:0], 1'b0});
      settle(2); chk(mac_term_code_o, i[3:0]);
    end
    xfer(0, 16'h1184, 0); chk(q, 16'h041e);
    // calibration bypass blocks the start request
    xfer(1, 16'h1140, 16'h2141);
    @(posedge clk_i);
    calr <= 1'b1;
    settle(2); chk(bypass_o, 1'b1); chk(cal_start_o, 1'b0);
    xfer(1, 16'h1140, 16'h0141);
    settle(2); chk(cal_start_o, 1'b1);
    @(posedge clk_i);
    calr <= 1'b0;
    // gap length with minimum gap enabled, then disabled
    for (int g = 0; g < 2; g++)
    begin
      xfer(1, 16'h1158, (g == 0) ? 16'h0008 : 16'h0000);
      pulse(3);
      n = 0;
      repeat (8) begin @(negedge clk_i); if (gap_open_o === 1'b0) n++; end
      chk(n, (g == 0) ? ipg_min_cyc : ipg_normal_cyc);
    end
    // second reset in mid-run restores the defaults
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    settle(1); chk(mac_term_code_o, 4'h8);
    xfer(0, 16'h1180, 0); chk(q, 16'h0551);
    xfer(0, 16'h1158, 0); chk(q, 16'h0008);
    give_verdict();
  end
endmodule

`default_nettype wire
